/* File: rsd_map.svh */
`ifndef RSD_MAP_SVH
`define RSD_MAP_SVH

// ----------------------------------------------------------------
// clock and delay figures
// ----------------------------------------------------------------
`define RSD_CLK_MHZ 125
`define RSD_OVL_DELAY_US 10
`define RSD_OL_DELAY_US 100

// ----------------------------------------------------------------
// widths and counts
// ----------------------------------------------------------------
`define RSD_NCH 8
`define RSD_FRAME_W 16
`define RSD_CNT_W 16
`define RSD_BIT_W 3
`define RSD_BYTE_W 2
`define RSD_SYNC_SPI_W 3
`define RSD_SYNC_CH_W 32

// ----------------------------------------------------------------
// reset values and codes
// ----------------------------------------------------------------
`define RSD_CTRL_RESET 16'hFFFF
`define RSD_DIAG_RESET 16'h0000
`define RSD_CTRL_SLEEP 16'h0000
`define RSD_TER_RESET 1'h1
`define RSD_BIT_ZERO 3'h0
`define RSD_BIT_LAST 3'h7
`define RSD_BIT_ONE 3'h1
`define RSD_BYTE_ZERO 2'h0
`define RSD_BYTE_ONE 2'h1
`define RSD_BYTE_MIN 2'h2
`define RSD_CNT_ONE 16'h0001

`endif

/* File: rsd_pkg.sv */
`default_nettype none

package rsd_pkg;
    `include "rsd_map.svh"

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        RSD_MODE_STANDBY = 2'h0,
        RSD_MODE_INPUT = 2'h1,
        RSD_MODE_ON = 2'h2,
        RSD_MODE_OFF = 2'h3
    } rsd_mode_t;

    typedef enum logic [1:0] {
        SPI_IDLE = 2'h1,
        SPI_ACTIVE = 2'h2
    } rsd_spi_st_t;

    typedef logic [`RSD_FRAME_W-1:0] rsd_frame_t;
    typedef logic [`RSD_NCH-1:0] rsd_chvec_t;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // diagnosis word: open-load odd bit, overload even bit
    function automatic rsd_frame_t rsd_diag_word(input rsd_chvec_t ol,
                                                 input rsd_chvec_t ovl);
        rsd_frame_t w;
        w = `RSD_DIAG_RESET;
        for (int i = 0; i < `RSD_NCH; i++) begin
            w[2*i+1] = ol[i];
            w[2*i] = ovl[i];
        end
        return w;
    endfunction : rsd_diag_word

    // frame length check: whole bytes, at least two of them
    function automatic logic rsd_frame_ok(
        input logic [`RSD_BIT_W-1:0] bits,
        input logic [`RSD_BYTE_W-1:0] bytes);
        return (bits == `RSD_BIT_ZERO) && (bytes >= `RSD_BYTE_MIN);
    endfunction : rsd_frame_ok

endpackage : rsd_pkg

`default_nettype wire

/* File: rsd_sync.sv */
`timescale 1ns/1ps
`default_nettype none

module rsd_sync #(
    parameter int WIDTH = 1
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // asynchronous in, synchronous out
    input wire logic [WIDTH-1:0] asyncIn,
    output logic [WIDTH-1:0] syncOut
);
    import rsd_pkg::*;

    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] meta_d;
    logic [WIDTH-1:0] sync_d;

    // ------------------------------------------------------------
    // two-stage synchroniser
    // ------------------------------------------------------------
    always_comb begin
        meta_d = asyncIn;
        sync_d = meta_q;
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_q <= '0;
            syncOut <= '0;
        end else begin
            meta_q <= meta_d;
            syncOut <= sync_d;
        end
    end

endmodule : rsd_sync

`default_nettype wire

/* File: rsd_channel.sv */
`timescale 1ns/1ps
`default_nettype none
`include "rsd_map.svh"

module rsd_channel #(
    parameter logic [15:0] OVL_CYC = 16'h0001,
    parameter logic [15:0] OL_CYC = 16'h0001
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // channel control
    input wire rsd_pkg::rsd_mode_t mode,
    input wire logic inPin,
    // protection and load sensing
    input wire logic ovlSense,
    input wire logic overTemp,
    input wire logic openLoadSense,
    // drive and flags
    output logic chanOn,
    output logic diagCurrentEn,
    output logic overloadFaultFlag,
    output logic openLoadFlag
);
    import rsd_pkg::*;

    logic stb;
    logic wantOn;
    logic onD;
    logic diagD;
    logic ovlD;
    logic olD;
    logic [`RSD_CNT_W-1:0] ovlCntQ;
    logic [`RSD_CNT_W-1:0] ovlCntD;
    logic [`RSD_CNT_W-1:0] olCntQ;
    logic [`RSD_CNT_W-1:0] olCntD;

    // ------------------------------------------------------------
    // mode decode, protection and off-state diagnosis
    // ------------------------------------------------------------
    always_comb begin
        stb = (mode == RSD_MODE_STANDBY);
        unique case (mode)
            RSD_MODE_STANDBY: wantOn = 1'b0;
            RSD_MODE_INPUT: wantOn = inPin;
            RSD_MODE_ON: wantOn = 1'b1;
            RSD_MODE_OFF: wantOn = 1'b0;
        endcase
        ovlD = overloadFaultFlag;
        olD = openLoadFlag;
        ovlCntD = '0;
        olCntD = '0;
        // overload must persist for the shutoff delay
        if (chanOn && ovlSense && !stb) begin
            if (ovlCntQ == OVL_CYC - `RSD_CNT_ONE) begin
                ovlD = 1'b1;
            end else begin
                ovlCntD = ovlCntQ + `RSD_CNT_ONE;
            end
        end
        // overtemperature sets the flag at once
        if (overTemp && !stb) begin
            ovlD = 1'b1;
        end
        // open-load only while off and not in standby
        if (!chanOn && !stb && openLoadSense) begin
            if (olCntQ == OL_CYC - `RSD_CNT_ONE) begin
                olD = 1'b1;
            end else begin
                olCntD = olCntQ + `RSD_CNT_ONE;
            end
        end
        // standby clears both flags
        if (stb) begin
            ovlD = 1'b0;
            olD = 1'b0;
        end
        onD = wantOn && !ovlD;
        diagD = !stb && !onD;
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            chanOn <= 1'b0;
            diagCurrentEn <= 1'b0;
            overloadFaultFlag <= 1'b0;
            openLoadFlag <= 1'b0;
            ovlCntQ <= '0;
            olCntQ <= '0;
        end else begin
            chanOn <= onD;
            diagCurrentEn <= diagD;
            overloadFaultFlag <= ovlD;
            openLoadFlag <= olD;
            ovlCntQ <= ovlCntD;
            olCntQ <= olCntD;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    a_flag_blocks_on: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        overloadFaultFlag |-> !chanOn)
        else $error("channel on while overload flag set");

    a_overtemp_off: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        overTemp && (mode != RSD_MODE_STANDBY)
        |=> overloadFaultFlag && !chanOn)
        else $error("overtemperature did not switch off");

    a_overload_timed: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        $rose(overloadFaultFlag)
        |-> $past(overTemp) || ($past(ovlCntQ) == OVL_CYC - `RSD_CNT_ONE))
        else $error("overload flag set before shutoff delay");

    a_standby_clear: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        mode == RSD_MODE_STANDBY |=> !overloadFaultFlag && !openLoadFlag
        && !chanOn && !diagCurrentEn)
        else $error("standby did not clear flags");

    a_flags_latched: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        (overloadFaultFlag || openLoadFlag) && mode != RSD_MODE_STANDBY
        |=> $stable({overloadFaultFlag, openLoadFlag}) || $rose(overloadFaultFlag)
        || $rose(openLoadFlag))
        else $error("fault flag cleared outside standby");

    a_ol_only_off: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        $rose(openLoadFlag) |-> !$past(chanOn)
        && ($past(olCntQ) == OL_CYC - `RSD_CNT_ONE))
        else $error("open-load flag set while on or early");

endmodule : rsd_channel

`default_nettype wire

/* File: rsd_top.sv */
// What this block does
// - overload on an on channel for the shutoff delay: off and flagged
// - a channel with its overload flag set stays off
// - overtemperature outside standby sets that channel's overload flag and switches it off
// - both flags stay latched; standby is the only clear
// - off channel outside standby with open-load sensed for the delay sets open-load flag
// - no open-load diagnosis while on, and the open-load flag never rises while on
// - off-state diagnosis active in off mode, disabled in standby
// - after reset all channels sit in idle off mode
// - full-duplex serial slave; chip select falling starts an access
// - serial input captured on each falling serial clock edge
// - serial output updated on each rising serial clock edge
// - accept frame only for whole bytes and at least 16 bits
// - serial registers return to defaults on reset
// - control field 00 standby, 01 follow pin, 10 on, 11 off
// - at select fall output shows error flag OR input level
// - data shifted most significant bit first both ways
// - diagnosis word holds open-load odd, overload even, channel 8 top
`timescale 1ns/1ps
`default_nettype none
`include "rsd_map.svh"

module rsd_top #(
    parameter int unsigned OL_DELAY_CYC = `RSD_OL_DELAY_US * `RSD_CLK_MHZ
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // serial port pins
    input wire logic spiClk,
    input wire logic spiCsN,
    input wire logic spiSi,
    output logic spiSo,
    output logic spiSoOe,
    // channel inputs
    input wire rsd_pkg::rsd_chvec_t chanInPin,
    input wire rsd_pkg::rsd_chvec_t ovlSense,
    input wire rsd_pkg::rsd_chvec_t overTemp,
    input wire rsd_pkg::rsd_chvec_t openLoadSense,
    // channel outputs
    output rsd_pkg::rsd_chvec_t chanOn,
    output rsd_pkg::rsd_chvec_t diagCurrentEn,
    output rsd_pkg::rsd_chvec_t overloadFaultFlag,
    output rsd_pkg::rsd_chvec_t openLoadFlag,
    // status
    output logic sleepMode,
    output logic transferErrorFlag
);
    import rsd_pkg::*;

    localparam int unsigned OVL_DELAY_CYC =
        `RSD_OVL_DELAY_US * `RSD_CLK_MHZ;

    // ------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------
    logic [`RSD_SYNC_SPI_W-1:0] spiRaw;
    logic [`RSD_SYNC_SPI_W-1:0] spiSync;
    logic [`RSD_SYNC_CH_W-1:0] chRaw;
    logic [`RSD_SYNC_CH_W-1:0] chSync;
    logic sclkS;
    logic csSelS;
    logic siS;
    rsd_chvec_t inPinS;
    rsd_chvec_t ovlS;
    rsd_chvec_t otempS;
    rsd_chvec_t olSenseS;

    // select inverted so every stage resets to zero
    assign spiRaw = {spiClk, ~spiCsN, spiSi};
    assign chRaw = {chanInPin, ovlSense, overTemp, openLoadSense};

    rsd_sync #(
        .WIDTH(`RSD_SYNC_SPI_W)
    ) u_sync_spi (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .asyncIn(spiRaw),
        .syncOut(spiSync)
    );

    rsd_sync #(
        .WIDTH(`RSD_SYNC_CH_W)
    ) u_sync_ch (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .asyncIn(chRaw),
        .syncOut(chSync)
    );

    // split synchronised groups
    assign {sclkS, csSelS, siS} = spiSync;
    assign {inPinS, ovlS, otempS, olSenseS} = chSync;

    // ------------------------------------------------------------
    // edge detection on synchronised serial pins
    // ------------------------------------------------------------
    logic sclkPrevQ;
    logic csPrevQ;
    logic sclkFall;
    logic sclkRise;
    logic csFall;
    logic csRise;

    always_comb begin
        sclkFall = sclkPrevQ && !sclkS;
        sclkRise = !sclkPrevQ && sclkS;
        csFall = !csPrevQ && csSelS;
        csRise = csPrevQ && !csSelS;
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            sclkPrevQ <= 1'b0;
            csPrevQ <= 1'b0;
        end else begin
            sclkPrevQ <= sclkS;
            csPrevQ <= csSelS;
        end
    end

    // ------------------------------------------------------------
    // serial frame engine
    // ------------------------------------------------------------
    rsd_spi_st_t stateQ;
    rsd_spi_st_t stateD;
    rsd_frame_t shiftQ;
    rsd_frame_t shiftD;
    rsd_frame_t ctrlQ;
    rsd_frame_t ctrlD;
    rsd_frame_t diagWord;
    logic [`RSD_BIT_W-1:0] bitCntQ;
    logic [`RSD_BIT_W-1:0] bitCntD;
    logic [`RSD_BYTE_W-1:0] byteCntQ;
    logic [`RSD_BYTE_W-1:0] byteCntD;
    logic terQ;
    logic terD;
    logic soD;
    logic soOeD;
    logic sleepD;
    logic frameOk;
    logic [`RSD_FRAME_W-2:0] shiftLow;

    assign diagWord = rsd_diag_word(openLoadFlag, overloadFaultFlag);
    assign frameOk = rsd_frame_ok(bitCntQ, byteCntQ);
    assign shiftLow = shiftQ[`RSD_FRAME_W-2:0];

    // next state of the serial engine
    always_comb begin
        stateD = stateQ;
        shiftD = shiftQ;
        ctrlD = ctrlQ;
        bitCntD = bitCntQ;
        byteCntD = byteCntQ;
        terD = terQ;
        soD = spiSo;
        soOeD = spiSoOe;
        unique case (stateQ)
            SPI_IDLE: begin
                if (csFall) begin
                    stateD = SPI_ACTIVE;
                    shiftD = diagWord;
                    soD = terQ || siS;
                    soOeD = 1'b1;
                    bitCntD = `RSD_BIT_ZERO;
                    byteCntD = `RSD_BYTE_ZERO;
                end
            end
            SPI_ACTIVE: begin
                if (csRise) begin
                    stateD = SPI_IDLE;
                    soD = 1'b0;
                    soOeD = 1'b0;
                    if (frameOk) begin
                        ctrlD = shiftQ;
                        terD = 1'b0;
                    end else begin
                        terD = 1'b1;
                    end
                end else begin
                    if (sclkFall) begin
                        shiftD = {shiftLow, siS};
                        bitCntD = bitCntQ + `RSD_BIT_ONE;
                        if (bitCntQ == `RSD_BIT_LAST &&
                            byteCntQ != `RSD_BYTE_MIN) begin
                            byteCntD = byteCntQ + `RSD_BYTE_ONE;
                        end
                    end
                    if (sclkRise) begin
                        soD = shiftQ[`RSD_FRAME_W-1];
                    end
                end
            end
            default: begin
                stateD = SPI_IDLE;
                soD = 1'b0;
                soOeD = 1'b0;
            end
        endcase
        sleepD = (ctrlD == `RSD_CTRL_SLEEP);
    end

    // serial engine registers, defaults after reset
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            stateQ <= SPI_IDLE;
            shiftQ <= `RSD_DIAG_RESET;
            ctrlQ <= `RSD_CTRL_RESET;
            bitCntQ <= `RSD_BIT_ZERO;
            byteCntQ <= `RSD_BYTE_ZERO;
            terQ <= `RSD_TER_RESET;
            spiSo <= 1'b0;
            spiSoOe <= 1'b0;
            sleepMode <= 1'b0;
        end else begin
            stateQ <= stateD;
            shiftQ <= shiftD;
            ctrlQ <= ctrlD;
            bitCntQ <= bitCntD;
            byteCntQ <= byteCntD;
            terQ <= terD;
            spiSo <= soD;
            spiSoOe <= soOeD;
            sleepMode <= sleepD;
        end
    end

    assign transferErrorFlag = terQ;

    // ------------------------------------------------------------
    // channels
    // ------------------------------------------------------------
    for (genvar i = 0; i < `RSD_NCH; i++) begin : g_ch
        rsd_channel #(
            .OVL_CYC(16'(OVL_DELAY_CYC)),
            .OL_CYC(16'(OL_DELAY_CYC))
        ) u_ch (
            .ref_clk(ref_clk),
            .rst_n(rst_n),
            .mode(rsd_mode_t'(ctrlQ[2*i +: 2])),
            .inPin(inPinS[i]),
            .ovlSense(ovlS[i]),
            .overTemp(otempS[i]),
            .openLoadSense(olSenseS[i]),
            .chanOn(chanOn[i]),
            .diagCurrentEn(diagCurrentEn[i]),
            .overloadFaultFlag(overloadFaultFlag[i]),
            .openLoadFlag(openLoadFlag[i])
        );
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    a_frame_accept: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        stateQ == SPI_ACTIVE && csRise && frameOk
        |=> ctrlQ == $past(shiftQ) && !terQ)
        else $error("valid frame not accepted");

    a_frame_reject: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        stateQ == SPI_ACTIVE && csRise && !frameOk
        |=> $stable(ctrlQ) && terQ)
        else $error("bad frame not rejected");

    a_shift_capture: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        stateQ == SPI_ACTIVE && sclkFall && !csRise
        |=> shiftQ == {$past(shiftLow), $past(siS)})
        else $error("input bit not shifted in");

    a_so_rise: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        stateQ == SPI_ACTIVE && sclkRise && !csRise
        |=> spiSo == $past(shiftQ[`RSD_FRAME_W-1]) && spiSoOe)
        else $error("output not updated on rising clock");

    a_so_select: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        stateQ == SPI_IDLE && csFall
        |=> spiSoOe && spiSo == ($past(terQ) || $past(siS))
        && shiftQ == $past(diagWord))
        else $error("wrong output at select fall");

    a_so_release: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        stateQ == SPI_ACTIVE && csRise |=> !spiSoOe ##1 !spiSoOe)
        else $error("output still driven after select rise");

endmodule : rsd_top

`default_nettype wire

/* File: rsd_host_model.sv */
`timescale 1ns/1ps
`default_nettype none

module rsd_host_model (
    // clock
    input wire logic ref_clk,
    // serial pins
    output logic spiClk,
    output logic spiCsN,
    output logic spiSi,
    input wire logic spiSoWire,
    // finished access
    output logic frameDone,
    output logic frameTer,
    output logic [31:0] frameRx
);
    localparam int HALF = 10; // 80 ns, half of the 160 ns link clock

    // idle pins: select high, link clock parked low
    initial begin
        spiClk = 1'b0;
        spiCsN = 1'b1;
        spiSi = 1'b0;
        frameDone = 1'b0;
        frameTer = 1'b0;
        frameRx = 32'h0;
    end

    // one access: msb first both ways, last bit read ends up in the lsb
    task automatic xfer(input int nBits, input logic [31:0] txWord);
        logic [31:0] rxw;
        logic terBit;
        rxw = 32'h0;
        @(posedge ref_clk);
        spiSi <= txWord[nBits-1];
        spiCsN <= 1'b0;
        repeat (HALF) @(posedge ref_clk);
        terBit = spiSoWire; // held until the first rising link clock
        for (int i = nBits - 1; i >= 0; i--) begin
            spiClk <= 1'b1;
            spiSi <= txWord[i];
            repeat (HALF) @(posedge ref_clk);
            rxw = {rxw[30:0], spiSoWire};
            spiClk <= 1'b0;
            repeat (HALF) @(posedge ref_clk);
        end
        spiCsN <= 1'b1;
        spiSi <= ~spiSi; // released data line shows no stale level
        repeat (HALF) @(posedge ref_clk);
        frameRx <= rxw;
        frameTer <= terBit;
        frameDone <= 1'b1;
        @(posedge ref_clk);
        frameDone <= 1'b0;
    endtask : xfer
endmodule : rsd_host_model

`default_nettype wire

/* File: rsd_top_tb.sv */
`timescale 1ns/1ps
`default_nettype none

module rsd_top_tb;
    import rsd_pkg::*;
    localparam int OL_CYC = 20;
    typedef struct {logic transfer_error_flag; logic [31:0] rx;} rsd_note_t;

    logic ref_clk;
    logic rst_n;
    wire logic spiClk;
    wire logic spiCsN;
    wire logic spiSi;
    wire spiSoWire;
    logic spiSo, spiSoOe, sleepMode, transferErrorFlag;
    logic frameDone, frameTer;
    logic [31:0] frameRx;
    rsd_chvec_t chanInPin, ovlSense, overTemp, openLoadSense, pin;
    rsd_chvec_t chanOn, diagCurrentEn, overloadFaultFlag, openLoadFlag;
    rsd_chvec_t expOl, expOvl;
    logic expTer;
    int fail_count = 0;
    int num_checks = 0;
    int n;
    rsd_note_t expQ[$];

    // ----------------------------------------------------------------
    // clock, pins and instances
    // ----------------------------------------------------------------
    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end

    // serial output floats while the block is not selected
    assign spiSoWire = spiSoOe ? spiSo : 1'bz;

    rsd_top #(.OL_DELAY_CYC(OL_CYC)) dut (.ref_clk(ref_clk), .rst_n(rst_n),
        .spiClk(spiClk), .spiCsN(spiCsN), .spiSi(spiSi), .spiSo(spiSo),
        .spiSoOe(spiSoOe), .chanInPin(chanInPin), .ovlSense(ovlSense),
        .overTemp(overTemp), .openLoadSense(openLoadSense),
        .chanOn(chanOn), .diagCurrentEn(diagCurrentEn),
        .overloadFaultFlag(overloadFaultFlag),
        .openLoadFlag(openLoadFlag), .sleepMode(sleepMode),
        .transferErrorFlag(transferErrorFlag));

    rsd_host_model host (.ref_clk(ref_clk), .spiClk(spiClk),
        .spiCsN(spiCsN), .spiSi(spiSi), .spiSoWire(spiSoWire),
        .frameDone(frameDone), .frameTer(frameTer), .frameRx(frameRx));

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    task automatic compare(input string what, input logic [31:0] got,
                           input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : compare

    task automatic stop_test();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : stop_test

    // expected read word from the modelled flags
    function automatic logic [15:0] diagWord();
        logic [15:0] w;
        for (int i = 0; i < 8; i++) w[2*i+:2] = {expOl[i], expOvl[i]};
        return w;
    endfunction : diagWord

    // one access with its expected answer noted first
    task automatic frame(input int nBits, input logic [31:0] tx);
        rsd_note_t e;
        e.transfer_error_flag = expTer | tx[nBits-1];
        e.rx = (nBits == 24) ? {8'h00, diagWord(), tx[23:16]} :
               (nBits == 12) ? {16'h0, diagWord() >> 4} : {16'h0, diagWord()};
        expQ.push_back(e);
        host.xfer(nBits, tx);
        expTer = (nBits % 8 != 0) || (nBits < 16);
    endtask : frame

    // oldest note against each finished access
    initial begin : watch
        rsd_note_t e;
        forever begin
            @(posedge ref_clk);
            if (frameDone === 1'b1 && expQ.size() > 0) begin
                e = expQ.pop_front();
                compare("error bit", {31'h0, frameTer}, {31'h0, e.transfer_error_flag});
                compare("read word", frameRx, e.rx);
            end
        end
    end

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin : main
        rst_n = 1'b0;
        {chanInPin, ovlSense, overTemp, openLoadSense} = 32'h0;
        {expOl, expOvl} = 16'h0;
        expTer = 1'b1;
        void'($urandom(46571));
        repeat (3) @(posedge ref_clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge ref_clk);
        compare("chanOn", chanOn, 8'h00);
        compare("diagCurrentEn", diagCurrentEn, 8'hFF);
        compare("error flag", transferErrorFlag, 1'b1);
        compare("sleepMode", sleepMode, 1'b0);
        $display("test reset done");
        // all four modes, then the input pin followed
        frame(16, 32'hFF36);
        compare("chanOn", chanOn, 8'h01);
        compare("diagCurrentEn", diagCurrentEn, 8'hF6);
        for (int i = 0; i < 4; i++) begin
            pin = rsd_chvec_t'($urandom);
            chanInPin <= pin;
            repeat (6) @(posedge ref_clk);
            compare("input follow", chanOn[1], pin[1]);
        end
        chanInPin <= 8'h00;
        $display("test modes done");
        // refused and long frames
        frame(12, 32'h000);
        compare("error flag", transferErrorFlag, 1'b1);
        compare("kept fields", diagCurrentEn[3:0], 4'h6);
        frame(24, 32'h25FF36);
        compare("error flag", transferErrorFlag, 1'b0);
        $display("test length done");
        // overtemperature on an on and an off channel
        overTemp <= 8'h05;
        repeat (6) @(posedge ref_clk);
        compare("chanOn", chanOn, 8'h00);
        compare("fault flags", overloadFaultFlag, 8'h05);
        expOvl = 8'h05;
        overTemp <= 8'h00;
        repeat (6) @(posedge ref_clk);
        compare("stays off", chanOn[0], 1'b0);
        frame(16, 32'h7F36);
        compare("stays off", chanOn[0], 1'b0);
        frame(16, 32'h0000);
        expOvl = 8'h00;
        compare("fault flags", overloadFaultFlag, 8'h00);
        compare("sleepMode", sleepMode, 1'b1);
        frame(16, 32'h7F36);
        compare("chanOn", chanOn, 8'h01);
        $display("test overtemp done");
        // overload must last the shutoff delay
        ovlSense <= 8'h01;
        repeat (1200) @(posedge ref_clk);
        compare("still on", chanOn[0], 1'b1);
        n = 0;
        while (overloadFaultFlag[0] !== 1'b1 && n < 100) begin
            @(posedge ref_clk);
            n++;
        end
        if (n >= 100) begin
            fail_count++;
            $display("Error overload flag expected 1 seen %b",
                     overloadFaultFlag[0]);
        end
        compare("switched off", chanOn[0], 1'b0);
        ovlSense <= 8'h00;
        expOvl = 8'h01;
        frame(16, 32'h0000);
        expOvl = 8'h00;
        $display("test overload done");
        // open load: off and input-off yes, on and standby no
        frame(16, 32'h7F36);
        openLoadSense <= 8'h0F;
        repeat (OL_CYC - 4) @(posedge ref_clk);
        compare("early open load", openLoadFlag, 8'h00);
        repeat (14) @(posedge ref_clk);
        compare("open load", openLoadFlag, 8'h06);
        openLoadSense <= 8'h00;
        repeat (6) @(posedge ref_clk);
        compare("latched", openLoadFlag, 8'h06);
        expOl = 8'h06;
        frame(16, 32'h7F36);
        $display("test open load done");
        // let the watcher take the last answer before the verdict
        repeat (2) @(posedge ref_clk);
        if (expQ.size() != 0) begin
            fail_count++;
            $display("Error answers left expected 0 seen %0d", expQ.size());
        end
        stop_test();
    end
endmodule : rsd_top_tb

`default_nettype wire
